// *** bfsp_flash_model.sv ***
// behavioural serial boot flash that answers one read command
`timescale 1ns/1ns
module bfsp_flash_model (
    input wire logic sel_b,
    input wire logic sck,
    input wire logic mosi,
    output logic miso,
    output logic [31:0] cmd
);
    int bit_cnt = 0;
    logic [7:0] cur;
    initial miso = 1'h0;
    // each select starts a fresh frame
    always @(negedge sel_b) begin
        bit_cnt = 0;
        cmd = 32'h0;
    end
    // command bits are caught on the rising clock edge
    always @(posedge sck) begin
        if (!sel_b && bit_cnt < 32) cmd = {cmd[30:0], mosi};
        if (!sel_b) bit_cnt = bit_cnt + 1;
    end
    // answer bits change just after the fall, well ahead of the next rise
    always @(negedge sck) begin
        cur = 8'((bit_cnt - 32) / 8) ^ 8'ha5;
        if (!sel_b && bit_cnt >= 32) miso = cur[7 - (bit_cnt - 32) % 8];
    end
    // line left floating: show the inverse so a stale bit cannot pass
    always @(posedge sel_b) miso = ~miso;
endmodule // bfsp_flash_model

// *** bfsp_master.sv ***
// boot flash serial master port: reads the firmware image over a mode 3 link
`timescale 1ns/1ns
// Behaviour
// - serial data out changes on the falling edge of the generated serial clock.
// - serial data in is sampled on the rising edge of the generated serial clock.
// - the link runs in clock mode 3, clock idle high with data taken on rising edges.
// - flash select is active low and is released with a weak pull-up while reset is held.
// - serial clock and data out are released with weak pull-downs while reset is held.
// - the firmware image is taken in over the serial input line.
// - reset is active low and holds the port control logic while it is low; the pin synchroniser flops and buffer entries are not reset.
// - the four straps are caught once on the first cycle after each reset release and then held until the next reset.
// - the boot read from flash runs only when the first strap read high.
// - the external reset passes a simple digital filter before it governs the port.
module bfsp_master #(
    parameter int unsigned ADDR_W = 24,
    parameter int unsigned LEN_W = 24
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [bfsp_pkg::STRAP_W-1:0] strap_in,
    input wire logic flash_serial_in,
    output bfsp_pkg::bfsp_pin_s flash_sel_b,
    output bfsp_pkg::bfsp_pin_s flash_clk,
    output bfsp_pkg::bfsp_pin_s flash_data_out,
    output logic [bfsp_pkg::STRAP_W-1:0] strap_reg,
    output logic strap_valid,
    output logic boot_busy,
    output logic boot_done,
    output logic boot_valid,
    output logic [7:0] boot_data,
    output logic boot_last,
    input wire logic boot_ready
);
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_CMD = 5'h02,
        ST_DATA = 5'h04,
        ST_STALL = 5'h08,
        ST_DONE = 5'h10
    } bfsp_state_e;

    localparam logic [$clog2(bfsp_pkg::RST_FILT_CYC+1)-1:0] FILT_MAX =
        ($clog2(bfsp_pkg::RST_FILT_CYC+1))'(bfsp_pkg::RST_FILT_CYC);
    localparam logic [$clog2(bfsp_pkg::HALF_PERIOD_CYC)-1:0] DIV_MAX =
        ($clog2(bfsp_pkg::HALF_PERIOD_CYC))'(bfsp_pkg::HALF_PERIOD_CYC - 1);
    // command word: opcode followed by the start address
    localparam int unsigned CMD_W = 8 + ADDR_W;

    logic rst_s1_reg, rst_s2_reg;
    logic [$clog2(bfsp_pkg::RST_FILT_CYC+1)-1:0] filt_cnt_reg;
    logic port_rst_b_reg;
    logic [1:0] din_sync_reg;
    logic [bfsp_pkg::STRAP_W-1:0] strap_s1_reg, strap_s2_reg;
    logic [$clog2(bfsp_pkg::HALF_PERIOD_CYC)-1:0] div_cnt_reg;
    logic sck_reg;
    bfsp_state_e state_reg;
    logic [CMD_W-1:0] sh_out_reg;
    logic [5:0] bit_cnt_reg;
    logic [7:0] sh_in_reg;
    logic [2:0] rx_bits_reg;
    logic [LEN_W-1:0] len_cnt_reg;
    bfsp_pkg::bfsp_word_s buf_reg [bfsp_pkg::BUF_DEPTH];
    logic buf_wr_reg, buf_rd_reg;
    logic [1:0] buf_cnt_reg;
    logic half_tick, fall_tick, rise_tick, active, buf_full, push;
    bfsp_pkg::bfsp_word_s push_word;

    // raw reset is a pin: two flops before the filter looks at it
    always_ff @(posedge mclk) begin
        rst_s1_reg <= rst_b;
        rst_s2_reg <= rst_s1_reg;
    end

    // glitch filter; assertion follows at once, release only after a stable run
    always_ff @(posedge mclk) begin
        if (!rst_s2_reg) begin
            filt_cnt_reg <= '0;
            port_rst_b_reg <= 1'b0;
        end else if (filt_cnt_reg != FILT_MAX) begin
            filt_cnt_reg <= filt_cnt_reg + 1'b1;
            port_rst_b_reg <= 1'b0;
        end else begin
            port_rst_b_reg <= 1'b1;
        end
    end

    // serial input and straps come from pins
    always_ff @(posedge mclk) begin
        din_sync_reg <= {din_sync_reg[0], flash_serial_in};
        strap_s1_reg <= strap_in;
        strap_s2_reg <= strap_s1_reg;
    end

    // straps caught once on the first cycle after release, then left alone
    always_ff @(posedge mclk) begin
        if (!port_rst_b_reg) begin
            strap_reg <= '0;
            strap_valid <= 1'b0;
        end else if (!strap_valid) begin
            strap_reg <= strap_s2_reg;
            strap_valid <= 1'b1;
        end
    end

    // clock divider gives the half period enable
    always_ff @(posedge mclk) begin
        if (!port_rst_b_reg || !active) begin
            div_cnt_reg <= '0;
        end else if (div_cnt_reg == DIV_MAX) begin
            div_cnt_reg <= '0;
        end else begin
            div_cnt_reg <= div_cnt_reg + 1'b1;
        end
    end

    assign active = (state_reg == ST_CMD) || (state_reg == ST_DATA);
    assign half_tick = active && (div_cnt_reg == DIV_MAX);
    assign fall_tick = half_tick && sck_reg;
    assign rise_tick = half_tick && !sck_reg;
    assign buf_full = (buf_cnt_reg == 2'(bfsp_pkg::BUF_DEPTH));

    // serial clock idles high between transfers
    always_ff @(posedge mclk) begin
        if (!port_rst_b_reg) begin
            sck_reg <= 1'b1;
        end else if (!active) begin
            sck_reg <= 1'b1;
        end else if (half_tick) begin
            sck_reg <= !sck_reg;
        end
    end

    // sequencer: command, then data bytes; stalls with clock high when buffer is full
    always_ff @(posedge mclk) begin
        if (!port_rst_b_reg) begin
            state_reg <= ST_IDLE;
            sh_out_reg <= '0;
            bit_cnt_reg <= '0;
            len_cnt_reg <= '0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (strap_valid && strap_reg[bfsp_pkg::STRAP_BOOT_NVM]) begin
                        state_reg <= ST_CMD;
                        sh_out_reg <= {bfsp_pkg::CMD_READ, ADDR_W'(bfsp_pkg::START_ADDR_RST)};
                        bit_cnt_reg <= 6'(CMD_W);
                        len_cnt_reg <= LEN_W'(bfsp_pkg::BOOT_LEN_RST);
                    end else if (strap_valid) begin
                        state_reg <= ST_DONE;
                    end
                end
                ST_CMD: begin
                    // the first bit already stands from the select fall, so the first
                    // fall must keep it or the opcode arrives shifted by one place
                    if (fall_tick && bit_cnt_reg != 6'(CMD_W)) begin
                        sh_out_reg <= {sh_out_reg[CMD_W-2:0], 1'b0};
                    end
                    if (rise_tick) begin
                        bit_cnt_reg <= bit_cnt_reg - 1'b1;
                        if (bit_cnt_reg == 6'd1) begin
                            state_reg <= ST_DATA;
                        end
                    end
                end
                ST_DATA: begin
                    if (push) begin
                        len_cnt_reg <= len_cnt_reg - 1'b1;
                        if (len_cnt_reg == LEN_W'(1)) begin
                            state_reg <= ST_DONE;
                        end else if (buf_cnt_reg == 2'd1 && !buf_rd_take()) begin
                            state_reg <= ST_STALL; // pause before the next byte starts
                        end
                    end
                end
                ST_STALL: begin
                    if (!buf_full) begin
                        state_reg <= ST_DATA;
                    end
                end
                ST_DONE: begin
                    state_reg <= ST_DONE;
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    function automatic logic buf_rd_take();
        return boot_valid && boot_ready;
    endfunction

    // receive shifter samples on rising edges of the serial clock
    always_ff @(posedge mclk) begin
        if (!port_rst_b_reg) begin
            sh_in_reg <= '0;
            rx_bits_reg <= '0;
        end else if (state_reg == ST_DATA && rise_tick) begin
            sh_in_reg <= {sh_in_reg[6:0], din_sync_reg[1]};
            rx_bits_reg <= rx_bits_reg + 1'b1;
        end
    end

    assign push = (state_reg == ST_DATA) && rise_tick && (rx_bits_reg == 3'd7);
    assign push_word = '{data: {sh_in_reg[6:0], din_sync_reg[1]},
                         last: (len_cnt_reg == LEN_W'(1))};

    // two-entry buffer so a stalled receiver loses no byte
    always_ff @(posedge mclk) begin
        if (!port_rst_b_reg) begin
            buf_wr_reg <= 1'b0;
            buf_rd_reg <= 1'b0;
            buf_cnt_reg <= '0;
        end else begin
            if (push) begin
                buf_reg[buf_wr_reg] <= push_word;
                buf_wr_reg <= !buf_wr_reg;
            end
            if (buf_rd_take()) begin
                buf_rd_reg <= !buf_rd_reg;
            end
            buf_cnt_reg <= buf_cnt_reg + 2'(push) - 2'(buf_rd_take());
        end
    end

    // registered user-side outputs from the buffer head
    always_ff @(posedge mclk) begin
        if (!port_rst_b_reg) begin
            boot_valid <= 1'b0;
            boot_data <= '0;
            boot_last <= 1'b0;
        end else begin
            boot_valid <= (buf_cnt_reg + 2'(push) - 2'(buf_rd_take())) != 2'd0;
            if (buf_rd_take() || !boot_valid) begin
                if (buf_cnt_reg - 2'(buf_rd_take()) != 2'd0) begin
                    boot_data <= buf_reg[buf_rd_reg ^ buf_rd_take()].data;
                    boot_last <= buf_reg[buf_rd_reg ^ buf_rd_take()].last;
                end else begin
                    boot_data <= push_word.data;
                    boot_last <= push_word.last;
                end
            end
        end
    end

    // status flags
    always_ff @(posedge mclk) begin
        if (!port_rst_b_reg) begin
            boot_busy <= 1'b0;
            boot_done <= 1'b0;
        end else begin
            boot_busy <= active || (state_reg == ST_STALL);
            boot_done <= (state_reg == ST_DONE);
        end
    end

    // pins: released with pulls during reset, driven afterwards
    always_ff @(posedge mclk) begin
        if (!port_rst_b_reg) begin
            flash_sel_b <= '{out: 1'b1, oe: 1'b0, pull_up: 1'b1};
            flash_clk <= '{out: 1'b0, oe: 1'b0, pull_up: 1'b0};
            flash_data_out <= '{out: 1'b0, oe: 1'b0, pull_up: 1'b0};
        end else begin
            flash_sel_b <= '{out: !(active || state_reg == ST_STALL), oe: 1'b1, pull_up: 1'b1};
            flash_clk <= '{out: sck_reg, oe: 1'b1, pull_up: 1'b0};
            flash_data_out <= '{out: sh_out_reg[CMD_W-1], oe: 1'b1, pull_up: 1'b0};
        end
    end
endmodule // bfsp_master

// *** bfsp_master_sva.sv ***
// assertion checker for the boot flash serial master port
`timescale 1ns/1ns
module bfsp_master_sva (
    input wire logic mclk,
    input wire logic rst_b,
    input bfsp_pkg::bfsp_pin_s flash_sel_b,
    input bfsp_pkg::bfsp_pin_s flash_clk,
    input bfsp_pkg::bfsp_pin_s flash_data_out,
    input logic [bfsp_pkg::STRAP_W-1:0] strap_reg,
    input logic strap_valid,
    input logic boot_busy,
    input logic boot_valid,
    input logic [7:0] boot_data,
    input wire logic boot_ready
);
    default clocking cb @(posedge mclk); endclocking
    // raw reset seen long enough to pass the synchroniser
    sequence s_rst_held;
        !rst_b [*4];
    endsequence
    property p_rst_pins;
        s_rst_held |=> !flash_sel_b.oe && flash_sel_b.pull_up && !flash_clk.oe
            && !flash_clk.pull_up && !flash_data_out.oe && !flash_data_out.pull_up;
    endproperty
    a_rst_pins: assert property (p_rst_pins) else $error("pins not released");
    property p_rst_status;
        s_rst_held |=> !boot_valid && !boot_busy && !strap_valid;
    endproperty
    a_rst_status: assert property (p_rst_status) else $error("status not cleared");
    property p_filter;
        disable iff (!rst_b) $rose(rst_b) |-> !flash_sel_b.oe [*8];
    endproperty
    a_filter: assert property (p_filter) else $error("reset release not filtered");
    property p_data_fall;
        disable iff (!rst_b) flash_sel_b.oe && !flash_sel_b.out && !$past(flash_sel_b.out)
            && $changed(flash_data_out.out) |-> !flash_clk.out;
    endproperty
    a_data_fall: assert property (p_data_fall) else $error("data moved with clock high");
    property p_clk_idle;
        disable iff (!rst_b) flash_sel_b.oe && flash_sel_b.out && flash_clk.oe |-> flash_clk.out;
    endproperty
    a_clk_idle: assert property (p_clk_idle) else $error("clock not idle high");
    property p_valid_hold;
        disable iff (!rst_b) boot_valid && !boot_ready |=> boot_valid && $stable(boot_data);
    endproperty
    a_valid_hold: assert property (p_valid_hold) else $error("byte lost in stall");
    property p_no_boot;
        disable iff (!rst_b) strap_valid && !strap_reg[0] |-> !boot_valid && !boot_busy;
    endproperty
    a_no_boot: assert property (p_no_boot) else $error("boot without strap");
    property p_strap_hold;
        disable iff (!rst_b) strap_valid && $past(strap_valid) |-> $stable(strap_reg);
    endproperty
    a_strap_hold: assert property (p_strap_hold) else $error("straps changed");
endmodule // bfsp_master_sva
bind bfsp_master bfsp_master_sva i_bfsp_master_sva (.mclk(mclk), .rst_b(rst_b),
    .flash_sel_b(flash_sel_b), .flash_clk(flash_clk), .flash_data_out(flash_data_out),
    .strap_reg(strap_reg), .strap_valid(strap_valid), .boot_busy(boot_busy),
    .boot_valid(boot_valid), .boot_data(boot_data), .boot_ready(boot_ready));

// *** bfsp_pkg.sv ***
// package for the boot flash serial master port: constants and carrier structs
package bfsp_pkg;
    // serial clock divider: half period in mclk cycles
    localparam int unsigned HALF_PERIOD_CYC = 4;
    // reset filter: cycles the raw reset must stay high before its release is believed
    localparam int unsigned RST_FILT_CYC = 4;
    // strap positions
    localparam int unsigned STRAP_BOOT_NVM = 0;
    localparam int unsigned STRAP_W = 4;
    // read command opcode and default transfer
    localparam logic [7:0] CMD_READ = 8'h03;
    localparam logic [23:0] START_ADDR_RST = 24'h000000;
    localparam logic [23:0] BOOT_LEN_RST = 24'h000100;
    // buffer depth
    localparam int unsigned BUF_DEPTH = 2;

    // pin group for one serial line: level out, output enable, pull selection
    typedef struct packed {
        logic out;
        logic oe;
        logic pull_up;
    } bfsp_pin_s;

    // boot data word with its last-byte mark
    typedef struct packed {
        logic [7:0] data;
        logic last;
    } bfsp_word_s;
endpackage

// *** test_bfsp_master.sv ***
// self-checking bench for the boot flash serial master port
`timescale 1ns/1ns
module test_bfsp_master;
    logic mclk = 1'h0;
    logic rst_b = 1'h0;
    logic boot_ready = 1'h0;
    logic [3:0] strap_in = 4'h1;
    bfsp_pkg::bfsp_pin_s sel, sck, dout;
    logic miso, strap_valid, boot_busy, boot_done, boot_valid, boot_last;
    logic [3:0] strap_reg;
    logic [7:0] boot_data;
    logic [31:0] cmd;
    int error_cnt = 0;
    int n_checks = 0;
    int cyc = 0;
    // pin levels with the pulls applied when released
    wire logic sel_lvl = sel.oe ? sel.out : sel.pull_up;
    wire logic sck_lvl = sck.oe ? sck.out : sck.pull_up;
    wire logic dout_lvl = dout.oe ? dout.out : dout.pull_up;
    bfsp_master i_bfsp_master (.mclk(mclk), .rst_b(rst_b), .strap_in(strap_in),
        .flash_serial_in(miso), .flash_sel_b(sel), .flash_clk(sck), .flash_data_out(dout),
        .strap_reg(strap_reg), .strap_valid(strap_valid), .boot_busy(boot_busy),
        .boot_done(boot_done), .boot_valid(boot_valid), .boot_data(boot_data),
        .boot_last(boot_last), .boot_ready(boot_ready));
    bfsp_flash_model i_bfsp_flash_model (.sel_b(sel_lvl), .sck(sck_lvl), .mosi(dout_lvl),
        .miso(miso), .cmd(cmd));
    // 25 MHz clock
    always #20 mclk = ~mclk;
    task end_sim;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", what, exp, got);
            error_cnt++;
        end
    endtask
    // hang guard: the full run needs about 20000 cycles
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            error_cnt = error_cnt + 1;
            end_sim();
        end
    end
    // reset with given straps; released reset must not free the pins at once
    task do_reset(input logic [3:0] s);
        @(posedge mclk);
        strap_in <= s;
        rst_b <= 1'h0;
        repeat (10) @(posedge mclk);
        #1 chk("pins in reset", 9'h140, {sel, sck, dout});
        @(posedge mclk);
        rst_b <= 1'h1;
        repeat (5) begin
            @(posedge mclk);
            #1 chk("sel enable", 1'h0, sel.oe);
        end
    endtask
    // boot bit low: nothing is read and the pins sit idle
    task t_skip;
        do_reset(4'he);
        repeat (40) @(posedge mclk);
        #1 chk("skip status", 3'h4, {boot_done, boot_busy, boot_valid});
        chk("idle pins", 4'hf, {sel.out, sel.oe, sck.out, sck.oe});
        chk("strap", 4'he, strap_reg);
        chk("strap valid", 1'h1, strap_valid);
    endtask
    // reset cut into a running transfer
    task t_abort;
        do_reset(4'h1);
        repeat (300) @(posedge mclk);
        #1 chk("busy", 1'h1, boot_busy);
        do_reset(4'h1);
    endtask
    // full image with a long consumer stall early on
    task t_boot;
        int w;
        do_reset(4'h1);
        for (int n = 0; n < 256; n++) begin
            w = 0;
            while (boot_valid !== 1'h1 && w < 5000) begin
                @(posedge mclk);
                #1 w++;
            end
            chk("valid", 1'h1, boot_valid);
            chk("byte", 8'(n) ^ 8'ha5, boot_data);
            chk("last", n == 255, boot_last);
            if (n == 4) begin
                repeat (600) @(posedge mclk);
                #1 chk("stalled link", 3'h5, {sck.out, sel.out, boot_busy});
            end
            @(posedge mclk);
            boot_ready <= 1'h1;
            @(posedge mclk);
            boot_ready <= 1'h0;
            #1;
        end
        w = 0;
        while (boot_done !== 1'h1 && w < 500) begin
            @(posedge mclk);
            #1 w++;
        end
        chk("command", {bfsp_pkg::CMD_READ, bfsp_pkg::START_ADDR_RST}, cmd);
        chk("done sel", 2'h3, {boot_done, sel.out});
        chk("strap", 4'h1, strap_reg);
    endtask
    initial begin
        t_skip();
        t_abort();
        t_boot();
        end_sim();
    end
endmodule // test_bfsp_master
